/* File: verilog/uhrl_top.sv */
// UDP host register link: address select, frame filter, register protocol
`timescale 1ns/1ps
`include "uhrl_defs.svh"
// What this block does
// - Own address from fixed default, non-volatile store, or BootP.
// - Select pins: 00 fixed, 01 stored, 10 BootP, 11 invalid.
// - Fixed option uses 192.168.1.121 regardless of stored data.
// - Stored option reads 16-bit words at locations 0x20 and 0x22.
// - BootP unanswered: request again about once a second.
// - Only ARP reply, ICMP echo reply, and UDP receive/send.
// - No fragments; packets never exceed 1500 bytes.
// - Register traffic arrives on UDP destination port 27181.
// - Read data returns to the requester's source port.
// - Register accesses travel as commands inside UDP payloads.
// - Up to eight address spaces, each with own pointer.
// - Block transfers walk successive increasing addresses.
// - Command word: W, A, C, 3-bit space, size, inc, count.
// - Count 1 to 127; zero count is an error.
// - Little endian, low byte first; addresses count bytes.
// - Indicators show received frame count unless user selected.
// - Keep a host-readable count of accepted UDP packets.
module uhrl_top #(
  parameter logic [31:0] BOOTP_CYCLES =
    32'(`UHRL_BOOTP_NS / `UHRL_CLK_NS)
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [1:0] addr_select,
  input wire logic [7:0] rx_data,
  input wire logic rx_valid,
  input wire logic rx_last,
  output logic rx_ready,
  output logic [7:0] tx_data,
  output logic tx_valid,
  input wire logic tx_ready,
  output uhrl_pkg::uhrl_ureg_t ureg_req,
  input wire logic [7:0] ureg_rdata,
  output logic nvm_rd,
  output logic [7:0] nvm_addr,
  input wire logic [15:0] nvm_rdata,
  input wire logic nvm_ack,
  output logic bootp_req,
  input wire logic bootp_assigned,
  input wire logic [31:0] bootp_ip,
  output uhrl_pkg::uhrl_reply_t reply,
  output logic [31:0] my_ip,
  output logic my_ip_valid,
  output logic lbp_error,
  input wire logic indicator_user_sel,
  input wire logic [3:0] indicator_user,
  output logic [3:0] indicator_output,
  output logic [15:0] received_udp_packet_count
);
  function automatic logic [15:0] hdr16(input logic [7:0] h [42],
                                        input logic [5:0] ofs);
    hdr16 = {h[ofs], h[6'(ofs + 6'h01)]};
  endfunction
  function automatic logic [31:0] hdr32(input logic [7:0] h [42],
                                        input logic [5:0] ofs);
    hdr32 = {hdr16(h, ofs), hdr16(h, 6'(ofs + 6'h02))};
  endfunction
  function automatic logic [3:0] size_bytes(input logic [1:0] s);
    size_bytes = 4'(4'h1 << s);
  endfunction

  logic [1:0] sel_s1_reg, sel_s2_reg, sel_s3_reg, sel_reg;
  logic [31:0] nvm_ip_reg;
  uhrl_pkg::uhrl_nvm_state_t nvm_state_reg;
  logic [31:0] tick_cnt_reg;
  logic [7:0] hdr_reg [42];
  logic [10:0] byte_cnt_reg;
  logic udp_ok_reg, frame_open_reg, pend_rd_reg;
  logic [31:0] rx_frame_cnt_reg;
  uhrl_pkg::uhrl_lbp_state_t lbp_state_reg;
  uhrl_pkg::uhrl_cmd_t cmd_reg;
  logic [7:0] lo_byte_reg;
  logic [15:0] ptr_reg [`UHRL_SPACES];
  logic [3:0] elem_byte_reg;
  logic [6:0] left_reg;
  logic beat, ip_ok, udp_hit, arp_hit, icmp_hit, elem_end;
  logic [15:0] byte_addr;

  // Pins come from jumpers outside the clock domain
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      sel_s1_reg <= 2'h0;
      sel_s2_reg <= 2'h0;
      sel_s3_reg <= 2'h0;
      sel_reg <= 2'h0;
    end
    else
    begin
      sel_s1_reg <= addr_select;
      sel_s2_reg <= sel_s1_reg;
      sel_s3_reg <= sel_s2_reg;
      if (sel_s2_reg == sel_s3_reg)
        sel_reg <= sel_s3_reg;
    end
  end

  // Stored address fetched once after reset, high word first
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      nvm_state_reg <= uhrl_pkg::NV_W20;
      nvm_ip_reg <= 32'h0000_0000;
      nvm_rd <= 1'b0;
      nvm_addr <= `UHRL_NVM_IP_HI;
    end
    else
    begin
      case (nvm_state_reg)
        uhrl_pkg::NV_W20:
        begin
          nvm_rd <= !nvm_ack;
          if (nvm_ack)
          begin
            nvm_ip_reg[31:16] <= nvm_rdata;
            nvm_addr <= `UHRL_NVM_IP_LO;
            nvm_state_reg <= uhrl_pkg::NV_W22;
          end
        end
        uhrl_pkg::NV_W22:
        begin
          nvm_rd <= !nvm_ack;
          if (nvm_ack)
          begin
            nvm_ip_reg[15:0] <= nvm_rdata;
            nvm_state_reg <= uhrl_pkg::NV_DONE;
          end
        end
        default:
          nvm_rd <= 1'b0;
      endcase
    end
  end

  // Address selection
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      my_ip <= `UHRL_IP_DEFAULT;
      my_ip_valid <= 1'b0;
    end
    else
    begin
      case (sel_reg)
        `UHRL_SEL_FIXED:
        begin
          my_ip <= `UHRL_IP_DEFAULT;
          my_ip_valid <= 1'b1;
        end
        `UHRL_SEL_NVM:
        begin
          my_ip <= nvm_ip_reg;
          my_ip_valid <= nvm_state_reg == uhrl_pkg::NV_DONE;
        end
        `UHRL_SEL_BOOTP:
        begin
          my_ip <= bootp_ip;
          my_ip_valid <= bootp_assigned;
        end
        default:
          my_ip_valid <= 1'b0;
      endcase
    end
  end

  // BootP retry pacing; a pulse per period until an address arrives
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      tick_cnt_reg <= 32'h0000_0000;
      bootp_req <= 1'b0;
    end
    else
    begin
      bootp_req <= 1'b0;
      if (sel_reg != `UHRL_SEL_BOOTP || bootp_assigned)
        tick_cnt_reg <= 32'h0000_0000;
      else if (tick_cnt_reg == 32'(BOOTP_CYCLES - 32'h0000_0001))
      begin
        tick_cnt_reg <= 32'h0000_0000;
        bootp_req <= 1'b1;
      end
      else
        tick_cnt_reg <= 32'(tick_cnt_reg + 32'h0000_0001);
    end
  end

  // Frame classification from the captured header
  always_comb
  begin
    beat = rx_valid && rx_ready;
    ip_ok = my_ip_valid && hdr16(hdr_reg, `UHRL_OFS_ETYPE) == `UHRL_ET_IPV4
      && hdr32(hdr_reg, `UHRL_OFS_DIP) == my_ip
      && (hdr16(hdr_reg, `UHRL_OFS_FRAG) & `UHRL_FRAG_MASK) == 16'h0000;
    udp_hit = ip_ok && hdr_reg[`UHRL_OFS_PROTO] == `UHRL_PROTO_UDP
      && hdr16(hdr_reg, `UHRL_OFS_DPORT) == `UHRL_LBP_PORT;
    icmp_hit = ip_ok && hdr_reg[`UHRL_OFS_PROTO] == `UHRL_PROTO_ICMP
      && hdr_reg[`UHRL_OFS_ICMP] == `UHRL_ICMP_ECHO;
    arp_hit = my_ip_valid
      && hdr16(hdr_reg, `UHRL_OFS_ETYPE) == `UHRL_ET_ARP
      && hdr16(hdr_reg, `UHRL_OFS_ARP_OP) == `UHRL_ARP_REQ
      && hdr32(hdr_reg, `UHRL_OFS_ARP_TIP) == my_ip;
    byte_addr = 16'(ptr_reg[cmd_reg.space] + 16'(elem_byte_reg));
    elem_end = elem_byte_reg == 4'(size_bytes(cmd_reg.size) - 4'h1);
  end

  // Header capture and frame bookkeeping
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      byte_cnt_reg <= 11'h000;
      udp_ok_reg <= 1'b0;
      frame_open_reg <= 1'b0;
      rx_frame_cnt_reg <= 32'h0000_0000;
      received_udp_packet_count <= 16'h0000;
      reply <= '0;
      for (int i = 0; i < 42; i++)
        hdr_reg[i] <= 8'h00;
    end
    else
    begin
      reply.arp <= 1'b0;
      reply.icmp <= 1'b0;
      reply.udp_done <= 1'b0;
      if (beat)
      begin
        frame_open_reg <= !rx_last;
        if (byte_cnt_reg < `UHRL_HDR_LEN)
          hdr_reg[6'(byte_cnt_reg)] <= rx_data;
        if (byte_cnt_reg == `UHRL_HDR_LEN)
          udp_ok_reg <= udp_hit;
        if (byte_cnt_reg > `UHRL_MAX_FRAME)
          udp_ok_reg <= 1'b0;
        if (byte_cnt_reg != 11'h7FF)
          byte_cnt_reg <= 11'(byte_cnt_reg + 11'h001);
        if (rx_last)
        begin
          byte_cnt_reg <= 11'h000;
          udp_ok_reg <= 1'b0;
          rx_frame_cnt_reg <= 32'(rx_frame_cnt_reg + 32'h0000_0001);
          // Anything else is dropped with no reply flag, though the frame count still counts it
          reply.arp <= arp_hit;
          reply.icmp <= icmp_hit && byte_cnt_reg <= `UHRL_MAX_FRAME;
          reply.udp_done <= udp_ok_reg;
          reply.peer_ip <= arp_hit ? hdr32(hdr_reg, `UHRL_OFS_ARP_SIP)
                                   : hdr32(hdr_reg, `UHRL_OFS_SIP);
          reply.peer_port <= hdr16(hdr_reg, `UHRL_OFS_SPORT);
          if (udp_ok_reg)
            received_udp_packet_count <=
              16'(received_udp_packet_count + 16'h0001);
        end
      end
    end
  end

  // Indicators
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      indicator_output <= 4'h0;
    else
      indicator_output <= indicator_user_sel ? indicator_user
                                             : rx_frame_cnt_reg[3:0];
  end

  // Command engine; stalls the receive stream while reads drain
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      lbp_state_reg <= uhrl_pkg::LB_HDR;
      cmd_reg <= '0;
      lo_byte_reg <= 8'h00;
      elem_byte_reg <= 4'h0;
      left_reg <= 7'h00;
      rx_ready <= 1'b1;
      ureg_req <= '0;
      lbp_error <= 1'b0;
      pend_rd_reg <= 1'b0;
      tx_valid <= 1'b0;
      tx_data <= 8'h00;
      for (int i = 0; i < `UHRL_SPACES; i++)
        ptr_reg[i] <= 16'h0000;
    end
    else
    begin
      ureg_req.rd <= 1'b0;
      ureg_req.wr <= 1'b0;
      lbp_error <= 1'b0;
      pend_rd_reg <= ureg_req.rd;
      tx_valid <= pend_rd_reg;
      if (pend_rd_reg)
        tx_data <= ureg_rdata;
      case (lbp_state_reg)
        uhrl_pkg::LB_HDR:
          if (beat && !rx_last && byte_cnt_reg == `UHRL_HDR_LEN - 11'h001)
            lbp_state_reg <= uhrl_pkg::LB_CMD_LO;
        uhrl_pkg::LB_CMD_LO:
          if (beat)
          begin
            lo_byte_reg <= rx_data;
            // First payload byte: the UDP verdict register lands only now
            lbp_state_reg <= rx_last ? uhrl_pkg::LB_HDR
              : (byte_cnt_reg == `UHRL_HDR_LEN ? udp_hit : udp_ok_reg)
                ? uhrl_pkg::LB_CMD_HI : uhrl_pkg::LB_DROP;
          end
        uhrl_pkg::LB_CMD_HI:
          if (beat)
          begin
            cmd_reg <= {rx_data, lo_byte_reg};
            elem_byte_reg <= 4'h0;
            left_reg <= lo_byte_reg[6:0];
            if (lo_byte_reg[6:0] == 7'h00)
            begin
              lbp_error <= 1'b1;
              lbp_state_reg <= rx_last ? uhrl_pkg::LB_HDR
                                       : uhrl_pkg::LB_DROP;
            end
            else if (rx_data[6])
              lbp_state_reg <= rx_last ? uhrl_pkg::LB_HDR
                                       : uhrl_pkg::LB_ADR_LO;
            else if (rx_data[7])
              lbp_state_reg <= rx_last ? uhrl_pkg::LB_HDR
                                       : uhrl_pkg::LB_WDATA;
            else
            begin
              lbp_state_reg <= uhrl_pkg::LB_RDATA;
              rx_ready <= 1'b0;
            end
          end
        uhrl_pkg::LB_ADR_LO:
          if (beat)
          begin
            lo_byte_reg <= rx_data;
            lbp_state_reg <= rx_last ? uhrl_pkg::LB_HDR
                                     : uhrl_pkg::LB_ADR_HI;
          end
        uhrl_pkg::LB_ADR_HI:
          if (beat)
          begin
            ptr_reg[cmd_reg.space] <= {rx_data, lo_byte_reg};
            if (cmd_reg.wr)
              lbp_state_reg <= rx_last ? uhrl_pkg::LB_HDR
                                       : uhrl_pkg::LB_WDATA;
            else
            begin
              lbp_state_reg <= uhrl_pkg::LB_RDATA;
              rx_ready <= 1'b0;
            end
          end
        uhrl_pkg::LB_WDATA:
          if (beat)
          begin
            ureg_req.wr <= 1'b1;
            ureg_req.info <= cmd_reg.info;
            ureg_req.space <= cmd_reg.space;
            ureg_req.addr <= byte_addr;
            ureg_req.wdata <= rx_data;
            elem_byte_reg <= elem_end ? 4'h0 : 4'(elem_byte_reg + 4'h1);
            if (elem_end && cmd_reg.inc)
              ptr_reg[cmd_reg.space] <= 16'(ptr_reg[cmd_reg.space]
                + 16'(size_bytes(cmd_reg.size)));
            if (elem_end)
              left_reg <= 7'(left_reg - 7'h01);
            if (rx_last)
              lbp_state_reg <= uhrl_pkg::LB_HDR;
            else if (elem_end && left_reg == 7'h01)
              lbp_state_reg <= uhrl_pkg::LB_CMD_LO;
          end
        uhrl_pkg::LB_RDATA:
          // tx_ready must mean room for three more bytes: two are in flight
          if (tx_ready)
          begin
            ureg_req.rd <= 1'b1;
            ureg_req.info <= cmd_reg.info;
            ureg_req.space <= cmd_reg.space;
            ureg_req.addr <= byte_addr;
            elem_byte_reg <= elem_end ? 4'h0 : 4'(elem_byte_reg + 4'h1);
            if (elem_end && cmd_reg.inc)
              ptr_reg[cmd_reg.space] <= 16'(ptr_reg[cmd_reg.space]
                + 16'(size_bytes(cmd_reg.size)));
            if (elem_end)
              left_reg <= 7'(left_reg - 7'h01);
            if (elem_end && left_reg == 7'h01)
            begin
              rx_ready <= 1'b1;
              lbp_state_reg <= frame_open_reg ? uhrl_pkg::LB_CMD_LO
                                              : uhrl_pkg::LB_HDR;
            end
          end
        uhrl_pkg::LB_DROP:
          if (beat && rx_last)
            lbp_state_reg <= uhrl_pkg::LB_HDR;
        default:
          lbp_state_reg <= uhrl_pkg::LB_HDR;
      endcase
    end
  end
endmodule // uhrl_top

/* File: verilog/uhrl_defs.svh */
// Constants for the UDP host register link
`ifndef UHRL_DEFS_SVH
`define UHRL_DEFS_SVH
`define UHRL_CLK_NS 25
`define UHRL_BOOTP_NS 1_000_000_000
`define UHRL_IP_DEFAULT 32'hC0A8_0179
`define UHRL_NVM_IP_HI 8'h20
`define UHRL_NVM_IP_LO 8'h22
`define UHRL_SEL_FIXED 2'h0
`define UHRL_SEL_NVM 2'h1
`define UHRL_SEL_BOOTP 2'h2
`define UHRL_HDR_LEN 11'h02A
`define UHRL_MAX_FRAME 11'h5EA
`define UHRL_ET_IPV4 16'h0800
`define UHRL_ET_ARP 16'h0806
`define UHRL_ARP_REQ 16'h0001
`define UHRL_PROTO_ICMP 8'h01
`define UHRL_PROTO_UDP 8'h11
`define UHRL_ICMP_ECHO 8'h08
`define UHRL_LBP_PORT 16'h6A2D
`define UHRL_FRAG_MASK 16'h3FFF
`define UHRL_OFS_ETYPE 6'h0C
`define UHRL_OFS_ARP_OP 6'h14
`define UHRL_OFS_ARP_SIP 6'h1C
`define UHRL_OFS_ARP_TIP 6'h26
`define UHRL_OFS_FRAG 6'h14
`define UHRL_OFS_PROTO 6'h17
`define UHRL_OFS_SIP 6'h1A
`define UHRL_OFS_DIP 6'h1E
`define UHRL_OFS_SPORT 6'h22
`define UHRL_OFS_DPORT 6'h24
`define UHRL_OFS_ICMP 6'h22
`define UHRL_SPACES 8
`endif

/* File: verilog/uhrl_pkg.sv */
// Types for the UDP host register link
package uhrl_pkg;
  typedef enum logic [2:0]
  {
    LB_HDR = 3'h0,
    LB_CMD_LO = 3'h1,
    LB_CMD_HI = 3'h3,
    LB_ADR_LO = 3'h2,
    LB_ADR_HI = 3'h6,
    LB_WDATA = 3'h7,
    LB_RDATA = 3'h5,
    LB_DROP = 3'h4
  } uhrl_lbp_state_t;
  typedef enum logic [1:0]
  {
    NV_W20 = 2'h0,
    NV_W22 = 2'h1,
    NV_DONE = 2'h3
  } uhrl_nvm_state_t;
  typedef struct packed {
    logic wr;
    logic addr_follows;
    logic info;
    logic [2:0] space;
    logic [1:0] size;
    logic inc;
    logic [6:0] count;
  } uhrl_cmd_t;
  typedef struct packed {
    logic rd;
    logic wr;
    logic info;
    logic [2:0] space;
    logic [15:0] addr;
    logic [7:0] wdata;
  } uhrl_ureg_t;
  typedef struct packed {
    logic arp;
    logic icmp;
    logic udp_done;
    logic [31:0] peer_ip;
    logic [15:0] peer_port;
  } uhrl_reply_t;
endpackage

/* File: test/uhrl_host_model.sv */
// Host-side frame source and read-data sink for the register link
`timescale 1ns/1ps
module uhrl_host_model (
  input wire logic clk,
  output logic [7:0] rx_data,
  output logic rx_valid,
  output logic rx_last,
  input wire logic rx_ready,
  input wire logic [7:0] tx_data,
  input wire logic tx_valid,
  output logic tx_ready
);
  // One unfragmented packet plus its header at most
  logic [7:0] frame [0:1513];
  int len;
  logic [7:0] got [$];
  initial
  begin
    rx_data = 8'h00;
    rx_valid = 1'b0;
    rx_last = 1'b0;
    tx_ready = 1'b1;
  end
  // Read data has no backpressure once issued, so take every pulse
  always @(posedge clk)
  begin
    if (tx_valid)
      got.push_back(tx_data);
  end
  // Bytes leave in buffer order; payload fields are low byte first
  task automatic send;
    int i;
    for (i = 0; i < len; i++)
    begin
      @(negedge clk);
      rx_data = frame[i];
      rx_valid = 1'b1;
      rx_last = (i == len - 1);
      do
        @(posedge clk);
      while (rx_ready !== 1'b1);
    end
    @(negedge clk);
    rx_valid = 1'b0;
    rx_last = 1'b0;
    // Released data must not keep showing the last byte
    rx_data = ~rx_data;
  endtask
endmodule // uhrl_host_model

/* File: test/uhrl_chk.sv */
// Port-level assertions for the UDP host register link
`timescale 1ns/1ps
`include "uhrl_defs.svh"
module uhrl_chk #(
  parameter logic [31:0] BOOTP_CYCLES = 32'h0000_0064
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [1:0] addr_select,
  input wire logic [7:0] rx_data,
  input wire logic rx_valid,
  input wire logic rx_last,
  input wire logic rx_ready,
  input wire logic [7:0] tx_data,
  input wire logic tx_valid,
  input wire uhrl_pkg::uhrl_ureg_t ureg_req,
  input wire logic [7:0] ureg_rdata,
  input wire logic nvm_ack,
  input wire logic [7:0] nvm_addr,
  input wire logic bootp_req,
  input wire logic bootp_assigned,
  input wire uhrl_pkg::uhrl_reply_t reply,
  input wire logic [31:0] my_ip,
  input wire logic my_ip_valid,
  input wire logic lbp_error,
  input wire logic indicator_user_sel,
  input wire logic [3:0] indicator_user,
  input wire logic [3:0] indicator_output,
  input wire logic [15:0] received_udp_packet_count
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);
  logic [31:0] gap_reg;
  logic armed_reg;
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      gap_reg <= 32'h0000_0000;
    else if (bootp_req)
      gap_reg <= 32'h0000_0001;
    else
      gap_reg <= gap_reg + 32'h0000_0001;
  end
  // Only a gap inside one unbroken BootP wait is measured
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      armed_reg <= 1'b0;
    else if (addr_select != `UHRL_SEL_BOOTP || bootp_assigned)
      armed_reg <= 1'b0;
    else if (bootp_req)
      armed_reg <= 1'b1;
  end
  a_fixed_addr: assert property (
    (addr_select == `UHRL_SEL_FIXED) [*6] |=>
    my_ip_valid && my_ip == `UHRL_IP_DEFAULT)
    else $error("fixed address not in use");
  a_nvm_order: assert property (
    nvm_ack && nvm_addr == `UHRL_NVM_IP_HI |=>
    nvm_addr == `UHRL_NVM_IP_LO)
    else $error("second stored word not fetched");
  a_bootp_gap: assert property (
    bootp_req && armed_reg |-> gap_reg == BOOTP_CYCLES)
    else $error("request spacing wrong");
  a_bootp_stop: assert property (
    bootp_assigned [*4] |-> !bootp_req)
    else $error("request after assignment");
  a_bootp_mode: assert property (
    (addr_select != `UHRL_SEL_BOOTP) [*6] |-> !bootp_req)
    else $error("request outside BootP mode");
  a_wr_data: assert property (
    ureg_req.wr |-> $past(rx_valid && rx_ready) &&
    ureg_req.wdata == $past(rx_data))
    else $error("write data not from last byte");
  a_rd_return: assert property (
    ureg_req.rd |-> ##2 tx_valid && tx_data == $past(ureg_rdata))
    else $error("read data not returned");
  a_reply_end: assert property (
    reply.arp || reply.icmp || reply.udp_done |->
    $past(rx_valid && rx_ready && rx_last))
    else $error("reply not at frame end");
  a_count_step: assert property (
    $changed(received_udp_packet_count) |-> received_udp_packet_count
    == $past(received_udp_packet_count) + 16'h0001)
    else $error("packet count jumped");
  a_ind_user: assert property (
    indicator_user_sel [*2] |-> indicator_output == $past(indicator_user))
    else $error("indicators ignore user bits");
  a_zero_err: assert property (
    lbp_error |-> $past(rx_valid && rx_ready))
    else $error("error pulse without command byte");
  c_arp: cover property (reply.arp);
  c_icmp: cover property (reply.icmp);
  c_read: cover property (ureg_req.rd);
  c_error: cover property (lbp_error);
endmodule // uhrl_chk
bind uhrl_top uhrl_chk #(.BOOTP_CYCLES(BOOTP_CYCLES)) i_uhrl_chk (
  .clk(clk), .arst_n(arst_n), .addr_select(addr_select),
  .rx_data(rx_data), .rx_valid(rx_valid), .rx_last(rx_last),
  .rx_ready(rx_ready), .tx_data(tx_data), .tx_valid(tx_valid),
  .ureg_req(ureg_req), .ureg_rdata(ureg_rdata), .nvm_ack(nvm_ack),
  .nvm_addr(nvm_addr), .bootp_req(bootp_req),
  .bootp_assigned(bootp_assigned), .reply(reply), .my_ip(my_ip),
  .my_ip_valid(my_ip_valid), .lbp_error(lbp_error),
  .indicator_user_sel(indicator_user_sel),
  .indicator_user(indicator_user), .indicator_output(indicator_output),
  .received_udp_packet_count(received_udp_packet_count)
);

/* File: test/test_udp_host_register_link.sv */
// Self-checking bench for the UDP host register link
`timescale 1ns/1ps
`include "uhrl_defs.svh"
module test_udp_host_register_link;
  localparam logic [31:0] BOOT = 32'h0000_0064;
  localparam logic [31:0] PEER = 32'h0A00_0002;
  localparam logic [31:0] DEF = `UHRL_IP_DEFAULT;
  typedef struct packed {
    logic [15:0] et;
    logic [7:0] pr;
    logic [31:0] ip;
    logic [15:0] dp;
    logic [15:0] fr;
    logic [2:0] ex;
  } uhrl_row_t;
  logic clk, arst_n, rx_valid, rx_last, rx_ready, tx_valid, tx_ready;
  logic nvm_rd, nvm_ack, bootp_req, bootp_assigned, my_ip_valid;
  logic lbp_error, indicator_user_sel;
  logic [1:0] addr_select;
  logic [7:0] rx_data, tx_data, ureg_rdata, nvm_addr;
  logic [15:0] nvm_rdata, received_udp_packet_count, cnt;
  logic [31:0] bootp_ip, my_ip;
  logic [3:0] indicator_user, indicator_output;
  logic [2:0] seen;
  uhrl_pkg::uhrl_ureg_t ureg_req;
  uhrl_pkg::uhrl_reply_t reply;
  logic [26:0] wq [$];
  time bq [$];
  int n_errors, n_checks, frames, n_lerr, k;
  uhrl_row_t rows [0:6];
  uhrl_row_t r;
  // Write, block write, read, pointer reuse, 16-bit write, zero count
  logic [7:0] pl [0:25] = '{8'h01, 8'hC0, 8'h10, 8'h00, 8'hD5, 8'h82,
    8'hC0, 8'h20, 8'h00, 8'hAA, 8'hBB, 8'h01, 8'h40, 8'h30, 8'h00,
    8'h01, 8'h80, 8'hEE, 8'h81, 8'hCD, 8'h40, 8'h00, 8'h11, 8'h22,
    8'h00, 8'h80};
  logic [26:0] ew [0:5] = '{27'h000_10D5, 27'h000_20AA, 27'h000_21BB,
    27'h000_30EE, 27'h300_4011, 27'h300_4122};
  uhrl_top #(.BOOTP_CYCLES(BOOT)) i_uhrl_top (
    .clk(clk), .arst_n(arst_n), .addr_select(addr_select),
    .rx_data(rx_data), .rx_valid(rx_valid), .rx_last(rx_last),
    .rx_ready(rx_ready), .tx_data(tx_data), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .ureg_req(ureg_req), .ureg_rdata(ureg_rdata),
    .nvm_rd(nvm_rd), .nvm_addr(nvm_addr), .nvm_rdata(nvm_rdata),
    .nvm_ack(nvm_ack), .bootp_req(bootp_req),
    .bootp_assigned(bootp_assigned), .bootp_ip(bootp_ip),
    .reply(reply), .my_ip(my_ip), .my_ip_valid(my_ip_valid),
    .lbp_error(lbp_error), .indicator_user_sel(indicator_user_sel),
    .indicator_user(indicator_user), .indicator_output(indicator_output),
    .received_udp_packet_count(received_udp_packet_count));
  uhrl_host_model i_uhrl_host_model (
    .clk(clk), .rx_data(rx_data), .rx_valid(rx_valid),
    .rx_last(rx_last), .rx_ready(rx_ready), .tx_data(tx_data),
    .tx_valid(tx_valid), .tx_ready(tx_ready));
  always #12.5 clk = ~clk;
  always @(posedge clk)
  begin
    if (ureg_req.wr)
      wq.push_back({ureg_req.space, ureg_req.addr, ureg_req.wdata});
    if (lbp_error)
      n_lerr++;
    if (bootp_req)
      bq.push_back($time);
    seen = seen | {reply.arp, reply.icmp, reply.udp_done};
  end
  // Register space answers a byte derived from the address
  always @(negedge clk)
  begin
    if (ureg_req.rd)
      ureg_rdata = ureg_req.addr[7:0] ^ 8'h5A;
  end
  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [63:0] s, input logic [63:0] e);
    n_checks++;
    if (s !== e)
    begin
      n_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic put(input int o, input logic [31:0] v, input int n);
    int j;
    for (j = 0; j < n; j++)
      i_uhrl_host_model.frame[o + j] = v[8 * (n - 1 - j) +: 8];
  endtask
  // Network fields go most significant byte first, unlike the payload
  task automatic frm(input uhrl_row_t x);
    int j;
    for (j = 0; j < 42; j++)
      put(j, 8'h00, 1);
    put(12, x.et, 2);
    if (x.et == `UHRL_ET_ARP)
    begin
      put(20, 16'h0001, 2);
      put(28, PEER, 4);
      put(38, x.ip, 4);
    end
    else
    begin
      put(14, 8'h45, 1);
      put(20, x.fr, 2);
      put(23, x.pr, 1);
      put(26, PEER, 4);
      put(30, x.ip, 4);
      put(34, 16'h0800, 2);
      put(36, x.dp, 2);
    end
    // Two trailing bytes: the UDP verdict needs payload after the header
    put(42, 16'h0180, 2);
    i_uhrl_host_model.len = 44;
  endtask
  task automatic go;
    seen = 3'h0;
    frames++;
    i_uhrl_host_model.send();
    repeat (3) @(negedge clk);
  endtask
  task automatic nvm_word(input logic [15:0] d);
    int j;
    for (j = 0; j < 50 && nvm_rd !== 1'b1; j++)
      @(negedge clk);
    nvm_rdata = d;
    nvm_ack = 1'b1;
    @(negedge clk);
    nvm_ack = 1'b0;
  endtask
  initial
  begin
    #500000;
    n_errors++;
    $display("watchdog expired");
    finish_test();
  end
  initial
  begin
    clk = 1'b0;
    arst_n = 1'b0;
    addr_select = `UHRL_SEL_FIXED;
    {nvm_rdata, nvm_ack, bootp_assigned, bootp_ip} = '0;
    {indicator_user_sel, indicator_user, ureg_rdata} = '0;
    {n_errors, n_checks, frames, n_lerr, seen} = '0;
    rows = '{'{16'h0806, 8'h00, DEF, 16'h0000, 16'h0000, 3'h4},
      '{16'h0806, 8'h00, 32'h0A00_0009, 16'h0000, 16'h0000, 3'h0},
      '{16'h0800, 8'h01, DEF, 16'h0000, 16'h0000, 3'h2},
      '{16'h0800, 8'h11, DEF, 16'h6A2D, 16'h0000, 3'h1},
      '{16'h0800, 8'h11, DEF, 16'h6A2C, 16'h0000, 3'h0},
      '{16'h0800, 8'h11, DEF, 16'h6A2D, 16'h2000, 3'h0},
      '{16'h0800, 8'h11, DEF, 16'h6A2D, 16'h0001, 3'h0}};
    repeat (5) @(negedge clk);
    chk({rx_ready, my_ip_valid, nvm_addr}, {2'h2, 8'h20});
    chk(my_ip, DEF);
    arst_n = 1'b1;
    nvm_word(16'h0A0A);
    chk(nvm_addr, `UHRL_NVM_IP_LO);
    nvm_word(16'h0B0B);
    repeat (8) @(negedge clk);
    chk({my_ip_valid, my_ip}, {1'b1, DEF});
    $display("reset and fixed address test done");
    for (k = 0; k < 7; k++)
    begin
      cnt = received_udp_packet_count;
      frm(rows[k]);
      go();
      chk(seen, rows[k].ex);
      chk(received_udp_packet_count, cnt + rows[k].ex[0]);
      chk(indicator_output, frames[3:0]);
    end
    chk(reply.peer_ip, PEER);
    $display("frame table done");
    frm(rows[3]);
    for (k = 0; k < 26; k++)
      put(42 + k, pl[k], 1);
    i_uhrl_host_model.len = 68;
    go();
    chk(wq.size(), 6);
    for (k = 0; k < 6; k++)
      chk(wq[k], ew[k]);
    chk(i_uhrl_host_model.got[0], 8'h6A);
    chk(reply.peer_port, 16'h0800);
    chk(n_lerr, 1);
    indicator_user_sel = 1'b1;
    indicator_user = 4'hA;
    repeat (2) @(negedge clk);
    chk(indicator_output, 4'hA);
    indicator_user_sel = 1'b0;
    $display("register protocol test done");
    addr_select = `UHRL_SEL_NVM;
    repeat (8) @(negedge clk);
    chk(my_ip, 32'h0A0A_0B0B);
    addr_select = `UHRL_SEL_BOOTP;
    repeat (8) @(negedge clk);
    chk(my_ip_valid, 1'b0);
    frm(rows[2]);
    go();
    chk(seen, 3'h0);
    bq.delete();
    repeat (250) @(negedge clk);
    chk(bq.size() > 1, 1'b1);
    chk((bq[1] - bq[0]) / 25, BOOT);
    bootp_ip = 32'h0A00_0063;
    bootp_assigned = 1'b1;
    repeat (8) @(negedge clk);
    chk({my_ip_valid, my_ip}, {1'b1, bootp_ip});
    bq.delete();
    r = rows[2];
    r.ip = bootp_ip;
    frm(r);
    go();
    chk(seen, 3'h2);
    repeat (200) @(negedge clk);
    chk(bq.size(), 0);
    $display("address select test done");
    addr_select = `UHRL_SEL_FIXED;
    arst_n = 1'b0;
    repeat (2) @(negedge clk);
    chk(received_udp_packet_count, 16'h0000);
    arst_n = 1'b1;
    repeat (8) @(negedge clk);
    chk(my_ip, DEF);
    $display("second reset test done");
    finish_test();
  end
endmodule // test_udp_host_register_link
